// ==== hw/sdp_debug_port.sv ====
// Single wire debug port: serial engine, memory commands and debug state control
//----------------------------------------
// What this block does
// RQ1: Memory commands run beside the CPU, using free bus cycles or stealing one.
// RQ2: Firmware commands pass on only while the debug state is active.
// RQ3: One two-way serial pin carries all traffic with the host.
// RQ4: Host enables firmware by debug-space byte write to the status register at $FF01.
// RQ5: Entering debug state maps registers and ROM over $FF00-$FFFF.
// RQ6: Entry comes from background command, tag hit, or enter-debug instruction.
// RQ7: Entry refused when firmware disabled; CPU resumes after a short hold.
// RQ8: Background entry waits for instruction boundary; tag entry precedes tagged instruction.
// RQ9: Special single-chip mode leaves reset with debug enabled and active.
// RQ10: Debug registers at $FF00-$FF06 only while active, debug logic only.
// RQ11: Peripherals with suspend control halt while active, resume afterwards.
// RQ12: Host starts every bit time with a falling edge.
// RQ13: MSB first, nominal 16 debug clocks per bit, pseudo open drain.
// RQ14: 512 debug clocks without host edge clear the command.
// RQ15: Bit start seen 0-1 cycle after edge; sample ten cycles later.
// RQ16: Device never drives the pin while receiving.
// RQ17: Host holds pin low at least two cycles when reading.
// RQ18: Returning a one drives a brief high pulse seven cycles after start.
// RQ19: Returning a zero drives low 13 cycles then briefly high.
// RQ20: Host samples returned bits about ten cycles after start.
// RQ21: No free cycle within 128 debug clocks freezes CPU to steal one.
// RQ22: Commands are 8-bit opcode, then 16-bit address and/or data; reads return 16.
// RQ23: Host waits 150 debug clocks before next command or read data.
// RQ24: Pin input is synchronised before falling edges are detected.
// RQ25: Received bits shift in; opcode decoded after eight bits.
//----------------------------------------
module sdp_debug_port
   import sdp_pkg::*;
(
   input wire logic i_clk_sys, // System clock
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic i_pin, // debug_serial_pin level
   output logic o_pin_out, // debug_serial_pin drive value
   output logic o_pin_oe, // debug_serial_pin drive enable
   input wire logic i_special_single_chip, // Mode strap
   input wire logic i_bus_free, // CPU leaves this bus cycle free
   input wire logic i_mem_ack, // Memory access done
   input wire logic [15:0] i_mem_rdata, // Memory read data
   output logic o_mem_req, // Memory access request
   output logic o_mem_we, // Access is a write
   output logic o_mem_byte, // Access is a byte
   output logic o_mem_dbg_space, // Debug registers and ROM mapped
   output logic [15:0] o_mem_addr, // Access address
   output logic [15:0] o_mem_wdata, // Write data
   output logic o_cpu_freeze, // Freeze CPU to steal a cycle
   input wire logic i_insn_boundary, // CPU at instruction boundary
   input wire logic i_tag_hit, // Tagged instruction about to execute
   input wire logic i_enter_debug_insn, // enter_debug_instruction executed
   input wire logic i_fw_exit, // Firmware returns to user program
   output logic o_debug_active, // background_debug_state active
   output logic o_map_debug, // Debug registers and ROM in map
   output logic o_periph_suspend, // Suspend-enabled peripherals halt
   output logic o_cpu_hold, // CPU held during refused entry
   output logic o_fw_cmd_valid, // Firmware command pulse
   output logic [7:0] o_fw_cmd // Firmware command opcode
);
   //----------------------------------------
   // Opcode decoding
   //----------------------------------------
   function automatic logic is_mem_cmd(input logic [7:0] op);
      return op[OP_HW_HI] & op[OP_HW_LO];
   endfunction

   //----------------------------------------
   // Pin synchroniser and debug_bit_clock divider
   //----------------------------------------
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   logic [3:0] div_cnt;
   logic tick;
   logic fall;
   logic strap_done;

   // Two flops, then edge history
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_prev <= 1'b1;
         div_cnt <= 4'h0;
         tick <= 1'b0;
      end else begin
         pin_meta <= i_pin;
         pin_sync <= pin_meta; // RQ24
         pin_prev <= pin_sync;
         div_cnt <= (div_cnt == BIT_CLK_DIV - 4'h1) ? 4'h0 : div_cnt + 4'h1;
         tick <= (div_cnt == BIT_CLK_DIV - 4'h1);
      end
   end

   assign fall = pin_prev & ~pin_sync; // RQ12 RQ24

   //----------------------------------------
   // Serial engine and memory commands
   //----------------------------------------
   sdp_state_e state, next_state;
   logic bit_active, next_bit_active;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [4:0] nbits, next_nbits;
   logic [15:0] shreg, next_shreg;
   logic [7:0] opcode, next_opcode;
   logic [9:0] idle_cnt, next_idle_cnt;
   logic [7:0] steal_cnt, next_steal_cnt;
   logic fw_enable, next_fw_enable;
   logic bg_request, next_bg_request;
   logic next_pin_out, next_pin_oe;
   logic next_mem_req, next_mem_we, next_mem_byte, next_mem_dbg;
   logic [15:0] next_mem_addr, next_mem_wdata;
   logic next_freeze;
   logic next_fw_valid;
   logic [7:0] next_fw_cmd;
   logic tx_bit;
   logic status_write;
   logic active;

   assign tx_bit = shreg[15]; // RQ13
   assign status_write = is_mem_cmd(opcode) & ~opcode[OP_READ_BIT] & opcode[OP_DBG_BIT]
                         & ~opcode[OP_WORD_BIT] & (o_mem_addr == DBG_STATUS_ADDR);

   // Next values of the serial and command state
   always_comb begin
      next_state = state;
      next_bit_active = bit_active;
      next_bit_cnt = bit_cnt;
      next_nbits = nbits;
      next_shreg = shreg;
      next_opcode = opcode;
      next_idle_cnt = idle_cnt;
      next_steal_cnt = steal_cnt;
      next_fw_enable = fw_enable;
      next_bg_request = bg_request;
      next_pin_out = 1'b0;
      next_pin_oe = 1'b0;
      next_mem_req = o_mem_req;
      next_mem_we = o_mem_we;
      next_mem_byte = o_mem_byte;
      next_mem_dbg = o_mem_dbg_space;
      next_mem_addr = o_mem_addr;
      next_mem_wdata = o_mem_wdata;
      next_freeze = o_cpu_freeze;
      next_fw_valid = 1'b0;
      next_fw_cmd = o_fw_cmd;
      // Background request consumed at instruction boundary; a new one decoded below wins
      if (bg_request && i_insn_boundary) begin
         next_bg_request = 1'b0; // RQ8
      end
      // Bit timing from perceived start
      if (fall && state != SDP_EXEC) begin
         next_bit_active = 1'b1; // RQ15
         next_bit_cnt = 5'h00;
         next_idle_cnt = 10'h000;
      end else if (tick) begin
         if (bit_active) begin
            next_bit_cnt = bit_cnt + 5'h01;
         end
         if (idle_cnt != IDLE_TIMEOUT) begin
            next_idle_cnt = idle_cnt + 10'h001;
         end
      end
      // Receive: sample ten ticks into the bit
      if (tick && bit_active && state != SDP_TX && state != SDP_EXEC && bit_cnt == RX_SAMPLE) begin
         next_bit_active = 1'b0;
         next_shreg = {shreg[14:0], pin_sync}; // RQ15 RQ25
         next_nbits = nbits + 5'h01;
         if (state == SDP_OPCODE && nbits == OPCODE_BITS - 5'h01) begin
            next_nbits = 5'h00; // RQ25
            next_opcode = {shreg[6:0], pin_sync};
            if ({shreg[6:0], pin_sync} == OP_BACKGROUND) begin
               next_bg_request = 1'b1; // RQ6
            end else if (is_mem_cmd({shreg[6:0], pin_sync})) begin
               next_state = SDP_ADDR; // RQ22
            end else if (active) begin
               next_fw_valid = 1'b1; // RQ2
               next_fw_cmd = {shreg[6:0], pin_sync};
            end
         end else if (state != SDP_OPCODE && nbits == WORD_BITS - 5'h01) begin
            next_nbits = 5'h00;
            if (state == SDP_ADDR) begin
               next_mem_addr = {shreg[14:0], pin_sync};
               next_state = opcode[OP_READ_BIT] ? SDP_EXEC : SDP_WDATA;
            end else begin
               next_mem_wdata = {shreg[14:0], pin_sync};
               next_state = SDP_EXEC;
            end
            next_mem_we = ~opcode[OP_READ_BIT];
            next_mem_byte = ~opcode[OP_WORD_BIT];
            next_mem_dbg = opcode[OP_DBG_BIT];
            next_steal_cnt = 8'h00;
         end
      end
      // Transmit: drive pin, shift at end of bit
      if (state == SDP_TX && bit_active) begin
         if (tx_bit) begin
            next_pin_oe = (bit_cnt == TX_ONE_PULSE); // RQ18
            next_pin_out = 1'b1;
         end else begin
            next_pin_oe = (bit_cnt <= TX_ZERO_LOW); // RQ19
            next_pin_out = (bit_cnt == TX_ZERO_LOW);
         end
         if (tick && bit_cnt == BIT_END) begin
            next_bit_active = 1'b0;
            next_pin_oe = 1'b0;
            next_shreg = {shreg[14:0], 1'b0}; // RQ13
            next_nbits = nbits + 5'h01;
            if (nbits == WORD_BITS - 5'h01) begin
               next_nbits = 5'h00;
               next_state = SDP_OPCODE;
            end
         end
      end
      // Execute: wait for free cycle, steal after timeout
      if (state == SDP_EXEC) begin
         next_bit_active = 1'b0;
         if (status_write) begin
            next_fw_enable = o_mem_wdata[STAT_ENABLE_BIT]; // RQ4
            next_state = SDP_OPCODE;
         end else if (opcode[OP_READ_BIT] && opcode[OP_DBG_BIT]
                      && o_mem_addr == DBG_STATUS_ADDR) begin
            next_shreg = {8'h00, fw_enable, active, 6'h00}; // RQ10
            next_state = SDP_TX;
         end else if (o_mem_req && i_mem_ack) begin
            next_mem_req = 1'b0;
            next_freeze = 1'b0;
            next_mem_dbg = 1'b0;
            next_shreg = i_mem_rdata;
            next_state = opcode[OP_READ_BIT] ? SDP_TX : SDP_OPCODE;
         end else begin
            next_mem_req = i_bus_free | o_cpu_freeze; // RQ1
            if (tick && steal_cnt != STEAL_WAIT) begin
               next_steal_cnt = steal_cnt + 8'h01;
            end
            if (steal_cnt == STEAL_WAIT) begin
               next_freeze = 1'b1; // RQ21
            end
         end
      end
      // Link timeout clears the command
      if (tick && idle_cnt == IDLE_TIMEOUT - 10'h001 && state != SDP_EXEC && !fall) begin
         next_state = SDP_OPCODE; // RQ14
         next_nbits = 5'h00;
         next_shreg = 16'h0000;
         next_opcode = 8'h00;
         next_bit_active = 1'b0;
         next_pin_oe = 1'b0;
      end
      // Strap: enabled out of reset in special single-chip mode
      if (!strap_done && i_special_single_chip) begin
         next_fw_enable = 1'b1; // RQ9
      end
   end

   // Register the serial and command state
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state <= SDP_OPCODE;
         bit_active <= 1'b0;
         bit_cnt <= 5'h00;
         nbits <= 5'h00;
         shreg <= 16'h0000;
         opcode <= 8'h00;
         idle_cnt <= 10'h000;
         steal_cnt <= 8'h00;
         fw_enable <= 1'b0;
         bg_request <= 1'b0;
         o_pin_out <= 1'b0;
         o_pin_oe <= 1'b0;
         o_mem_req <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_byte <= 1'b0;
         o_mem_dbg_space <= 1'b0;
         o_mem_addr <= 16'h0000;
         o_mem_wdata <= 16'h0000;
         o_cpu_freeze <= 1'b0;
         o_fw_cmd_valid <= 1'b0;
         o_fw_cmd <= 8'h00;
      end else begin
         state <= next_state;
         bit_active <= next_bit_active;
         bit_cnt <= next_bit_cnt;
         nbits <= next_nbits;
         shreg <= next_shreg;
         opcode <= next_opcode;
         idle_cnt <= next_idle_cnt;
         steal_cnt <= next_steal_cnt;
         fw_enable <= next_fw_enable;
         bg_request <= next_bg_request;
         o_pin_out <= next_pin_out; // RQ3
         o_pin_oe <= next_pin_oe; // RQ16
         o_mem_req <= next_mem_req;
         o_mem_we <= next_mem_we;
         o_mem_byte <= next_mem_byte;
         o_mem_dbg_space <= next_mem_dbg;
         o_mem_addr <= next_mem_addr;
         o_mem_wdata <= next_mem_wdata;
         o_cpu_freeze <= next_freeze;
         o_fw_cmd_valid <= next_fw_valid;
         o_fw_cmd <= next_fw_cmd;
      end
   end

   //----------------------------------------
   // Debug state activation
   //----------------------------------------
   logic next_active;
   logic next_strap_done;
   logic [3:0] hold_cnt, next_hold_cnt;
   logic entry_req;

   assign active = o_debug_active;
   assign entry_req = (bg_request & i_insn_boundary) | i_tag_hit | i_enter_debug_insn; // RQ6 RQ8

   // Next activation state
   always_comb begin
      next_active = active;
      next_strap_done = 1'b1;
      next_hold_cnt = hold_cnt;
      if (!strap_done && i_special_single_chip) begin
         next_active = 1'b1; // RQ9
      end else if (active && i_fw_exit) begin
         next_active = 1'b0; // RQ11
      end else if (entry_req && !active && hold_cnt == 4'h0) begin
         if (fw_enable) begin
            next_active = 1'b1; // RQ5
         end else begin
            next_hold_cnt = REJECT_DELAY; // RQ7
         end
      end else if (hold_cnt != 4'h0) begin
         next_hold_cnt = hold_cnt - 4'h1;
      end
   end

   // Register activation state
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         strap_done <= 1'b0;
         hold_cnt <= 4'h0;
         o_debug_active <= 1'b0;
         o_map_debug <= 1'b0;
         o_periph_suspend <= 1'b0;
         o_cpu_hold <= 1'b0;
      end else begin
         strap_done <= next_strap_done;
         hold_cnt <= next_hold_cnt;
         o_debug_active <= next_active;
         o_map_debug <= next_active; // RQ5 RQ10
         o_periph_suspend <= next_active; // RQ11
         o_cpu_hold <= (next_hold_cnt != 4'h0); // RQ7
      end
   end

   //----------------------------------------
   // Checks
   //----------------------------------------
   property p_no_drive_rx;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state != SDP_TX && $past(state) != SDP_TX) |-> !o_pin_oe;
   endproperty
   a_no_drive_rx: assert property (p_no_drive_rx) else $error("pin driven while receiving"); // RQ16

   property p_sample;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (tick && bit_active && bit_cnt == RX_SAMPLE && state == SDP_ADDR)
      |=> (shreg[0] == $past(pin_sync)) && !bit_active;
   endproperty
   a_sample: assert property (p_sample) else $error("receive sample wrong"); // RQ15

   property p_zero_low;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDP_TX && bit_active && !tx_bit && bit_cnt < TX_ZERO_LOW)
      |=> (o_pin_oe && !o_pin_out);
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("zero not held low"); // RQ19

   property p_one_pulse;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDP_TX && bit_active && tx_bit && bit_cnt != TX_ONE_PULSE) |=> !o_pin_oe;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("one driven outside pulse"); // RQ18

   property p_timeout;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (tick && idle_cnt == IDLE_TIMEOUT - 10'h001 && state != SDP_EXEC && !fall)
      |=> (state == SDP_OPCODE && nbits == 5'h00 && shreg == 16'h0000);
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not clear"); // RQ14

   property p_steal;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == SDP_EXEC && steal_cnt == STEAL_WAIT && !i_mem_ack && !status_write
       && !opcode[OP_READ_BIT]) |=> o_cpu_freeze;
   endproperty
   a_steal: assert property (p_steal) else $error("no cycle steal after wait"); // RQ21

   property p_freeze_exec;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_cpu_freeze |-> (state == SDP_EXEC && steal_cnt == STEAL_WAIT);
   endproperty
   a_freeze_exec: assert property (p_freeze_exec) else $error("freeze outside command"); // RQ1

   property p_fw_active;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_fw_cmd_valid |-> $past(o_debug_active);
   endproperty
   a_fw_active: assert property (p_fw_active) else $error("firmware command while inactive"); // RQ2

   property p_activate;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_enter_debug_insn && fw_enable && !o_debug_active && hold_cnt == 4'h0 && strap_done)
      |=> (o_debug_active && o_map_debug && o_periph_suspend);
   endproperty
   a_activate: assert property (p_activate) else $error("debug state not entered"); // RQ6

   property p_reject;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (entry_req && !fw_enable && !o_debug_active && hold_cnt == 4'h0 && strap_done)
      |=> (o_cpu_hold && !o_debug_active) [*8] ##1 !o_cpu_hold;
   endproperty
   a_reject: assert property (p_reject) else $error("refused entry hold wrong"); // RQ7
endmodule

// ==== inc/sdp_pkg.sv ====
// Constants and types shared by the single wire debug port
package sdp_pkg;
   //----------------------------------------
   // Clocking
   //----------------------------------------
   localparam int CLK_SYS_MHZ = 100; // System clock rate
   localparam logic [3:0] BIT_CLK_DIV = 4'h2; // System cycles per debug_bit_clock tick
   //----------------------------------------
   // Serial bit timing, in debug_bit_clock cycles; REJECT_DELAY in system cycles
   //----------------------------------------
   localparam logic [4:0] BIT_NOMINAL = 5'h10; // Nominal bit time, 16
   localparam logic [4:0] RX_SAMPLE = 5'h0A; // Receive sample point, 10
   localparam logic [4:0] TX_ONE_PULSE = 5'h07; // Speed-up pulse for a one, 7
   localparam logic [4:0] TX_ZERO_LOW = 5'h0D; // Low time for a zero, 13
   localparam logic [4:0] BIT_END = 5'h0F; // Last tick of a bit time
   localparam logic [9:0] IDLE_TIMEOUT = 10'h200; // Link timeout, 512
   localparam logic [7:0] STEAL_WAIT = 8'h80; // Wait for free cycle, 128
   localparam logic [3:0] REJECT_DELAY = 4'h8; // Hold before resuming, refused entry
   //----------------------------------------
   // Command format
   //----------------------------------------
   localparam logic [4:0] OPCODE_BITS = 5'h08; // Opcode length
   localparam logic [4:0] WORD_BITS = 5'h10; // Address and data length
   localparam logic [7:0] OP_BACKGROUND = 8'h90; // Enter debug state
   localparam int OP_HW_HI = 7; // Bits 7:6 = 11 mark a memory command
   localparam int OP_HW_LO = 6;
   localparam int OP_READ_BIT = 5; // 1 = read
   localparam int OP_WORD_BIT = 3; // 1 = word
   localparam int OP_DBG_BIT = 2; // 1 = debug space mapped
   //----------------------------------------
   // Debug space map
   //----------------------------------------
   localparam logic [7:0] DBG_PAGE = 8'hFF; // $FF00-$FFFF
   localparam logic [15:0] DBG_STATUS_ADDR = 16'hFF01; // Status register
   localparam int STAT_ENABLE_BIT = 7; // firmware_enable_bit
   localparam int STAT_ACTIVE_BIT = 6; // Debug state active
   //----------------------------------------
   // Protocol states
   //----------------------------------------
   typedef enum logic [2:0] {
      SDP_OPCODE,
      SDP_ADDR,
      SDP_WDATA,
      SDP_EXEC,
      SDP_TX
   } sdp_state_e;
endpackage

// ==== verification/sdp_host_model.sv ====
// Host side of the debug serial pin: bit timing for sending and receiving
module sdp_host_model (
   input wire logic i_clk_sys, // System clock
   input wire logic i_pin, // Resolved pin level
   output logic o_low // Host pulls the pin low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sending = 1'b0; // Host owns the bit time
   initial o_low = 1'b0;
   //----------------------------------------
   // Bit time tasks
   //----------------------------------------
   // Send n bits MSB first, a zero held low past the sample point
   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge i_clk_sys) o_low <= 1'b1;
         sending <= 1'b1;
         repeat (v[i] ? 4 : 26) @(posedge i_clk_sys);
         o_low <= 1'b0;
         repeat (v[i] ? 32 : 10) @(posedge i_clk_sys);
         sending <= 1'b0;
      end
   endtask
   // Read n bits: short low start, release, sample near ten ticks
   task automatic recv(input int n, output logic [15:0] r);
      r = 16'h0000;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk_sys) o_low <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         o_low <= 1'b0;
         repeat (16) @(posedge i_clk_sys);
         #1 r = {r[14:0], i_pin};
         repeat (16) @(posedge i_clk_sys);
      end
   endtask
endmodule

// ==== verification/test_single_wire_debug_port.sv ====
// Self-checking bench for the single wire debug port
module test_single_wire_debug_port
   import sdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, ssc = 1'b0, bus_free = 1'b0, ack = 1'b0, starve = 1'b0;
   logic [3:0] ev = 4'h0; // Exit, enter insn, tag hit, boundary
   logic [15:0] rdata = 16'h0000, addr, wdata, s_addr, s_wdata;
   logic [15:0] mem [logic [15:0]];
   logic [3:0] s_flags; // Write, byte, debug space, freeze at ack
   logic [7:0] fw_cmd;
   logic pin_out, pin_oe, req, we, bacc, dbgsp, freeze, active, map, susp, hold, fw_v, low;
   int fails = 0, checks_done = 0, fw_pulses = 0, wcnt = 0;
   wire pin = pin_oe ? pin_out : ~low; // Pull-up when nobody drives
   sdp_debug_port DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_pin(pin), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .i_special_single_chip(ssc), .i_bus_free(bus_free), .i_mem_ack(ack),
      .i_mem_rdata(rdata), .o_mem_req(req), .o_mem_we(we), .o_mem_byte(bacc),
      .o_mem_dbg_space(dbgsp), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_cpu_freeze(freeze),
      .i_insn_boundary(ev[0]), .i_tag_hit(ev[1]), .i_enter_debug_insn(ev[2]), .i_fw_exit(ev[3]),
      .o_debug_active(active), .o_map_debug(map), .o_periph_suspend(susp), .o_cpu_hold(hold),
      .o_fw_cmd_valid(fw_v), .o_fw_cmd(fw_cmd));
   sdp_host_model host (.i_clk_sys(clk), .i_pin(pin), .o_low(low));
   initial forever #5 clk = ~clk;
   //----------------------------------------
   // Checking and closing
   //----------------------------------------
   task automatic fail(input string m);
      fails++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask
   task automatic final_report();
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Memory and CPU side: random free cycles, short acknowledge wait
   always @(posedge clk) begin
      bus_free <= starve ? 1'b0 : 1'($urandom_range(1, 0));
      ack <= 1'b0;
      if (req && !ack) begin
         if (wcnt == 0) begin
            ack <= 1'b1;
            rdata <= mem.exists(addr) ? mem[addr] : ~addr;
            if (we) mem[addr] = wdata;
            {s_addr, s_wdata, s_flags} <= {addr, wdata, we, bacc, dbgsp, freeze};
            wcnt <= $urandom_range(3, 0);
         end else wcnt <= wcnt - 1;
      end
      if (fw_v) fw_pulses <= fw_pulses + 1;
      if (host.sending && pin_oe !== 1'b0) fail("pin driven while host sends");
   end
   // Pulse one CPU event, check state outputs a cycle later
   task automatic ev_chk(input int k, input logic act, input logic hld);
      @(posedge clk) ev[k] <= 1'b1;
      @(posedge clk) ev <= 4'h0;
      #1 chk(16'({act, act, act, hld}), 16'({active, map, susp, hold}));
   endtask
   task automatic hold_len();
      int n;
      n = 1;
      while (hold === 1'b1 && n < 50) @(posedge clk) #1 n++;
      if (n >= 50) begin
         fail("refused entry hold never ended");
         final_report();
      end
      chk(16'(n - 1), 16'(REJECT_DELAY));
   endtask
   // Hardware command, host wait before read data and after
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
         output logic [15:0] r);
      r = 16'h0000;
      host.send({8'h00, op}, 8);
      host.send(a, 16);
      if (op[5]) begin
         repeat (400) @(posedge clk);
         host.recv(16, r);
      end else host.send(d, 16);
      repeat (400) @(posedge clk);
   endtask
   task automatic op8(input logic [7:0] op);
      host.send({8'h00, op}, 8);
      repeat (40) @(posedge clk);
   endtask
   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial begin
      logic [15:0] a, d, r;
      logic [7:0] ops [8];
      ops = '{8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hE0, 8'hE4, 8'hE8, 8'hEC};
      void'($urandom(32'hF9F3869A));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(16'({active, pin_oe, req}), 16'h0000);
      ev_chk(2, 1'b0, 1'b1);
      hold_len();
      op8(8'h90);
      #1 chk(16'(active), 16'h0000);
      ev_chk(0, 1'b0, 1'b1);
      hold_len();
      host.send(16'h000C, 4);
      repeat (1100) @(posedge clk);
      cmd(8'hC4, DBG_STATUS_ADDR, 16'h0080, r);
      cmd(8'hE4, DBG_STATUS_ADDR, 16'h0000, r);
      chk(r, 16'h0080);
      op8(8'h62);
      chk(16'(fw_pulses), 16'h0000);
      op8(8'h90);
      #1 chk(16'(active), 16'h0000);
      ev_chk(0, 1'b1, 1'b0);
      cmd(8'hE4, DBG_STATUS_ADDR, 16'h0000, r);
      chk(r, 16'h00C0);
      op8(8'h62);
      chk({fw_cmd, 8'(fw_pulses)}, 16'h6201);
      ev_chk(3, 1'b0, 1'b0);
      for (int k = 1; k < 3; k++) begin
         ev_chk(k, 1'b1, 1'b0);
         ev_chk(3, 1'b0, 1'b0);
      end
      // Write then read back each address, last pair with the bus starved
      for (int i = 0; i < 4; i++) begin
         a = 16'($urandom()) & 16'hFEFE;
         d = 16'($urandom());
         starve <= (i == 3);
         cmd(ops[i], a, d, r);
         chk(s_addr, a);
         chk(s_wdata, d);
         chk(16'(s_flags), 16'({1'b1, ~ops[i][3], ops[i][2], i == 3}));
         cmd(ops[i + 4], a, 16'h0000, r);
         chk(r, d);
         chk(16'(s_flags), 16'({1'b0, ~ops[i][3], ops[i][2], i == 3}));
      end
      ssc <= 1'b1;
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(16'({active, map}), 16'h0003);
      final_report();
   end
   // Cut a hang short
   initial begin
      repeat (100000) @(posedge clk);
      fail("run limit reached");
      final_report();
   end
endmodule
